// *** nand_host_pkg.sv ***
// Package with command codes, geometry, timing and carrier types of the flash host
package nand_host_pkg;

  // Array geometry
  localparam int PAGE_COUNT      = 65536;
  localparam int PAGE_BYTES      = 2112;
  localparam int SPARE_FIRST_COL = 2048;
  localparam int SPARE_LAST_COL  = 2111;
  localparam int BLOCK_COUNT     = 1024;
  localparam int PAGES_PER_BLOCK = 64;
  localparam int ADDR_BITS       = 28;
  localparam int COL_BITS        = 12;
  localparam int ROW_BITS        = 16;

  // Command codes
  localparam logic [7:0] CMD_READ_SETUP  = 8'h00;
  localparam logic [7:0] CMD_READ_GO     = 8'h30;
  localparam logic [7:0] CMD_COPY_READ   = 8'h35;
  localparam logic [7:0] CMD_READ_ID     = 8'h90;
  localparam logic [7:0] CMD_RESET       = 8'hFF;
  localparam logic [7:0] CMD_PROG_SETUP  = 8'h80;
  localparam logic [7:0] CMD_PROG_GO     = 8'h10;
  localparam logic [7:0] CMD_COPY_PROG   = 8'h85;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO    = 8'hD0;
  localparam logic [7:0] CMD_RAND_OUT    = 8'h05;
  localparam logic [7:0] CMD_RAND_OUT_GO = 8'hE0;
  localparam logic [7:0] CMD_STATUS      = 8'h70;
  localparam logic [7:0] CMD_EDC_STATUS  = 8'h7B;

  // Timing in ns and cycles at the 100 ns clock
  localparam int CLK_NS      = 100;
  localparam int T_ADL_NS    = 100;
  localparam int T_WHR_NS    = 60;
  localparam int T_RHW_NS    = 100;
  localparam int T_WB_NS     = 100;
  localparam int ADL_CYC     = (T_ADL_NS + CLK_NS - 1) / CLK_NS;
  localparam int WHR_CYC     = (T_WHR_NS + CLK_NS - 1) / CLK_NS;
  localparam int RHW_CYC     = (T_RHW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WB_CYC      = (T_WB_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int GAP_MAX     = 3;

  // Operation codes given on the request port
  typedef enum logic [3:0] {
    OP_READ, OP_COPY_READ, OP_READ_ID, OP_RESET, OP_PROGRAM, OP_COPY_PROG,
    OP_ERASE, OP_RAND_IN, OP_RAND_OUT, OP_STATUS, OP_EDC_STATUS
  } op_t;

  // One request from the user side
  typedef struct packed {
    op_t                   op;
    logic [ADDR_BITS-1:0]  addr;
    logic [COL_BITS-1:0]   count;
  } req_t;

  // Flash pin group driven by the host
  typedef struct packed {
    logic       chipSelN;
    logic       cmdLatch;
    logic       addrLatch;
    logic       writeStrobeN;
    logic       readStrobeN;
    logic       writeProtN;
  } pins_t;

  // Kind of one bus cycle
  typedef enum logic [1:0] {
    CYC_CMD, CYC_ADDR, CYC_WDATA, CYC_RDATA
  } cyc_t;

endpackage

// *** nand_bus_cycle.sv ***
// One flash bus cycle: write strobe or read strobe pulse with latch lines
`timescale 1ns/1ns
module nand_bus_cycle (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  clkEn,
  input  wire logic                  start,
  input  wire nand_host_pkg::cyc_t   kind,
  input  wire logic [7:0]            wrByte,
  input  wire logic [7:0]            ioInSync,
  output logic                       done,
  output logic [7:0]                 rdByte_r,
  output logic                       cmdLatch_r,
  output logic                       addrLatch_r,
  output logic                       writeStrobeN_r,
  output logic                       readStrobeN_r,
  output logic [7:0]                 ioOut_r,
  output logic                       ioOe_r
);

  typedef enum logic [1:0] {B_IDLE, B_LOW, B_SAMPLE, B_HIGH} bstate_t;

  bstate_t    state_r, state_nxt;
  logic [7:0] rdByte_nxt, ioOut_nxt;
  logic       cle_nxt, ale_nxt, we_nxt, re_nxt, oe_nxt;

  // Strobe low one cycle, high at least three cycles between pulses; latch lines held across the cycle
  always_comb begin
    state_nxt  = state_r;
    rdByte_nxt = rdByte_r;
    ioOut_nxt  = ioOut_r;
    cle_nxt    = cmdLatch_r;
    ale_nxt    = addrLatch_r;
    we_nxt     = writeStrobeN_r;
    re_nxt     = readStrobeN_r;
    oe_nxt     = ioOe_r;
    done       = 1'b0;
    case (state_r)
      B_IDLE: begin
        if (start) begin
          cle_nxt   = (kind == nand_host_pkg::CYC_CMD);
          ale_nxt   = (kind == nand_host_pkg::CYC_ADDR);
          oe_nxt    = (kind != nand_host_pkg::CYC_RDATA);
          re_nxt    = (kind != nand_host_pkg::CYC_RDATA);
          ioOut_nxt = wrByte;
          state_nxt = B_LOW;
        end
      end
      B_LOW: begin
        // Write strobe lags setup; read strobe ends early so both sync stages see the byte
        if (kind != nand_host_pkg::CYC_RDATA) begin
          we_nxt = 1'b0;
        end
        re_nxt    = 1'b1;
        state_nxt = B_SAMPLE;
      end
      B_SAMPLE: begin
        we_nxt    = 1'b1;
        re_nxt    = 1'b1;
        state_nxt = B_HIGH;
      end
      B_HIGH: begin
        // Read byte sampled after two sync stages, strobe already high
        if (kind == nand_host_pkg::CYC_RDATA) begin
          rdByte_nxt = ioInSync;
        end
        cle_nxt   = 1'b0;
        ale_nxt   = 1'b0;
        oe_nxt    = 1'b0;
        done      = 1'b1;
        state_nxt = B_IDLE;
      end
      default: state_nxt = B_IDLE;
    endcase
  end

  // Registers of the bus cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r        <= B_IDLE;
      rdByte_r       <= 8'h00;
      ioOut_r        <= 8'h00;
      cmdLatch_r     <= 1'b0;
      addrLatch_r    <= 1'b0;
      writeStrobeN_r <= 1'b1;
      readStrobeN_r  <= 1'b1;
      ioOe_r         <= 1'b0;
    end else if (clkEn) begin
      state_r        <= state_nxt;
      rdByte_r       <= rdByte_nxt;
      ioOut_r        <= ioOut_nxt;
      cmdLatch_r     <= cle_nxt;
      addrLatch_r    <= ale_nxt;
      writeStrobeN_r <= we_nxt;
      readStrobeN_r  <= re_nxt;
      ioOe_r         <= oe_nxt;
    end
  end

endmodule

// *** nand_host_ctrl.sv ***
// Host sequencer that drives a multiplexed 8-bit flash through its pins
`timescale 1ns/1ns
module nand_host_ctrl (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  clkEn,
  // User request port
  input  wire logic                  reqValid,
  output logic                       reqReady,
  input  wire nand_host_pkg::req_t   req,
  input  wire logic                  wrValid,
  output logic                       wrReady,
  input  wire logic [7:0]            wrData,
  output logic                       rdValid_r,
  output logic [7:0]                 rdData_r,
  output logic                       opDone,
  output logic                       refused,
  output logic                       flashReady,
  // Flash pins
  output nand_host_pkg::pins_t       pins,
  output logic [7:0]                 ioOut,
  output logic                       ioOe,
  input  wire logic [7:0]            ioIn,
  input  wire logic                  readyBusyN
);

  typedef enum logic [3:0] {
    S_IDLE, S_CMD1, S_ADDR, S_GAP, S_DATA, S_CMD2, S_BUSYWAIT, S_WAITRDY, S_FINISH
  } state_t;

  state_t      state_r, state_nxt;
  nand_host_pkg::req_t cur_r, cur_nxt;
  logic [2:0]  addrIdx_r, addrIdx_nxt;
  logic [2:0]  addrEnd_r, addrEnd_nxt;
  logic [11:0] left_r, left_nxt;
  logic [2:0]  gap_r, gap_nxt;
  logic        copyDone_r, copyDone_nxt;
  logic        rdValid_nxt;
  logic        bcStart, bcDone;
  nand_host_pkg::cyc_t bcKind;
  logic [7:0]  bcByte;
  logic        cle, ale, weN, reN;
  logic [7:0]  ioMeta_r, ioSync_r;
  logic        rbMeta_r, rbSync_r;

  // Setup command for each operation; only codes of the defined set
  function automatic logic [7:0] firstCmd(input nand_host_pkg::op_t op);
    case (op)
      nand_host_pkg::OP_READ,
      nand_host_pkg::OP_COPY_READ:  firstCmd = nand_host_pkg::CMD_READ_SETUP;
      nand_host_pkg::OP_READ_ID:    firstCmd = nand_host_pkg::CMD_READ_ID;
      nand_host_pkg::OP_RESET:      firstCmd = nand_host_pkg::CMD_RESET;
      nand_host_pkg::OP_PROGRAM:    firstCmd = nand_host_pkg::CMD_PROG_SETUP;
      nand_host_pkg::OP_COPY_PROG,
      nand_host_pkg::OP_RAND_IN:    firstCmd = nand_host_pkg::CMD_COPY_PROG;
      nand_host_pkg::OP_ERASE:      firstCmd = nand_host_pkg::CMD_ERASE_SETUP;
      nand_host_pkg::OP_RAND_OUT:   firstCmd = nand_host_pkg::CMD_RAND_OUT;
      nand_host_pkg::OP_EDC_STATUS: firstCmd = nand_host_pkg::CMD_EDC_STATUS;
      default:                      firstCmd = nand_host_pkg::CMD_STATUS;
    endcase
  endfunction

  // Confirm command, or none for one-cycle operations
  function automatic logic [7:0] secondCmd(input nand_host_pkg::op_t op);
    case (op)
      nand_host_pkg::OP_READ:      secondCmd = nand_host_pkg::CMD_READ_GO;
      nand_host_pkg::OP_COPY_READ: secondCmd = nand_host_pkg::CMD_COPY_READ;
      nand_host_pkg::OP_PROGRAM,
      nand_host_pkg::OP_COPY_PROG: secondCmd = nand_host_pkg::CMD_PROG_GO;
      nand_host_pkg::OP_ERASE:     secondCmd = nand_host_pkg::CMD_ERASE_GO;
      nand_host_pkg::OP_RAND_OUT:  secondCmd = nand_host_pkg::CMD_RAND_OUT_GO;
      default:                     secondCmd = 8'h00;
    endcase
  endfunction

  function automatic logic hasSecond(input nand_host_pkg::op_t op);
    hasSecond = (op == nand_host_pkg::OP_READ) || (op == nand_host_pkg::OP_COPY_READ)
             || (op == nand_host_pkg::OP_PROGRAM) || (op == nand_host_pkg::OP_COPY_PROG)
             || (op == nand_host_pkg::OP_ERASE) || (op == nand_host_pkg::OP_RAND_OUT);
  endfunction

  // Operations that leave the device busy after the last command
  function automatic logic makesBusy(input nand_host_pkg::op_t op);
    makesBusy = (op == nand_host_pkg::OP_READ) || (op == nand_host_pkg::OP_COPY_READ)
             || (op == nand_host_pkg::OP_PROGRAM) || (op == nand_host_pkg::OP_COPY_PROG)
             || (op == nand_host_pkg::OP_ERASE) || (op == nand_host_pkg::OP_RESET);
  endfunction

  // Commands the device takes while busy
  function automatic logic busyOk(input nand_host_pkg::op_t op);
    busyOk = (op == nand_host_pkg::OP_RESET) || (op == nand_host_pkg::OP_STATUS)
          || (op == nand_host_pkg::OP_EDC_STATUS);
  endfunction

  // Address cycle window: first index and one past last
  function automatic logic [5:0] addrRange(input nand_host_pkg::op_t op);
    case (op)
      nand_host_pkg::OP_READ, nand_host_pkg::OP_COPY_READ,
      nand_host_pkg::OP_PROGRAM, nand_host_pkg::OP_COPY_PROG:
                                   addrRange = {3'd0, 3'd4};
      nand_host_pkg::OP_ERASE:     addrRange = {3'd2, 3'd4};
      nand_host_pkg::OP_RAND_IN,
      nand_host_pkg::OP_RAND_OUT:  addrRange = {3'd0, 3'd2};
      nand_host_pkg::OP_READ_ID:   addrRange = {3'd0, 3'd1};
      default:                     addrRange = {3'd0, 3'd0};
    endcase
  endfunction

  // Address byte order: two column bytes then two row bytes
  function automatic logic [7:0] addrByte(input logic [27:0] a, input logic [2:0] i);
    case (i)
      3'd0:    addrByte = a[7:0];
      3'd1:    addrByte = {4'h0, a[11:8]};
      3'd2:    addrByte = a[19:12];
      default: addrByte = a[27:20];
    endcase
  endfunction

  function automatic logic writesData(input nand_host_pkg::op_t op);
    writesData = (op == nand_host_pkg::OP_PROGRAM) || (op == nand_host_pkg::OP_RAND_IN)
              || (op == nand_host_pkg::OP_COPY_PROG);
  endfunction

  // Pin inputs pass two flip-flops before use
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ioMeta_r <= 8'h00;
      ioSync_r <= 8'h00;
      rbMeta_r <= 1'b0;
      rbSync_r <= 1'b0;
    end else if (clkEn) begin
      ioMeta_r <= ioIn;
      ioSync_r <= ioMeta_r;
      rbMeta_r <= readyBusyN;
      rbSync_r <= rbMeta_r;
    end
  end

  assign flashReady = rbSync_r;

  nand_bus_cycle nand_bus_cycle_i (
    .clock          (clock),
    .rst            (rst),
    .clkEn          (clkEn),
    .start          (bcStart),
    .kind           (bcKind),
    .wrByte         (bcByte),
    .ioInSync       (ioSync_r),
    .done           (bcDone),
    .rdByte_r       (rdData_r),
    .cmdLatch_r     (cle),
    .addrLatch_r    (ale),
    .writeStrobeN_r (weN),
    .readStrobeN_r  (reN),
    .ioOut_r        (ioOut),
    .ioOe_r         (ioOe)
  );

  // Chip held selected; write protect released
  assign pins = '{chipSelN: 1'b0, cmdLatch: cle, addrLatch: ale,
                  writeStrobeN: weN, readStrobeN: reN, writeProtN: 1'b1};

  // Sequencer: command, address, data and confirm cycles
  always_comb begin
    state_nxt    = state_r;
    cur_nxt      = cur_r;
    addrIdx_nxt  = addrIdx_r;
    addrEnd_nxt  = addrEnd_r;
    left_nxt     = left_r;
    gap_nxt      = gap_r;
    copyDone_nxt = copyDone_r;
    rdValid_nxt  = 1'b0;
    reqReady     = 1'b0;
    wrReady      = 1'b0;
    opDone       = 1'b0;
    refused      = 1'b0;
    bcStart      = 1'b0;
    bcKind       = nand_host_pkg::CYC_CMD;
    bcByte       = firstCmd(cur_r.op);
    case (state_r)
      S_IDLE: begin
        reqReady = 1'b1;
        if (reqValid) begin
          // Busy device or stray error-detect read is refused
          if ((!rbSync_r && !busyOk(req.op)) ||
              (req.op == nand_host_pkg::OP_EDC_STATUS && !copyDone_r)) begin
            refused = 1'b1;
          end else begin
            cur_nxt     = req;
            addrIdx_nxt = 3'(addrRange(req.op) >> 3);
            addrEnd_nxt = 3'(addrRange(req.op));
            left_nxt    = req.count;
            state_nxt   = S_CMD1;
          end
        end
      end
      S_CMD1: begin
        bcStart = 1'b1;
        if (bcDone) begin
          bcStart   = 1'b0;
          state_nxt = (addrIdx_r != addrEnd_r) ? S_ADDR : S_GAP;
          gap_nxt   = 3'(nand_host_pkg::GAP_MAX);
        end
      end
      S_ADDR: begin
        bcStart = 1'b1;
        bcKind  = nand_host_pkg::CYC_ADDR;
        bcByte  = addrByte(cur_r.addr, addrIdx_r);
        if (bcDone) begin
          bcStart     = 1'b0;
          addrIdx_nxt = addrIdx_r + 3'd1;
          if (addrIdx_r + 3'd1 == addrEnd_r) begin
            state_nxt = S_GAP;
            gap_nxt   = 3'(nand_host_pkg::GAP_MAX); // Covers address-to-data and WE-to-RE
          end
        end
      end
      S_GAP: begin
        if (gap_r != 3'd0) begin
          gap_nxt = gap_r - 3'd1;
        end else if (left_r != 12'h000 && cur_r.op != nand_host_pkg::OP_RESET
                     && !hasSecond(cur_r.op) || (left_r != 12'h000
                     && writesData(cur_r.op))) begin
          state_nxt = S_DATA;
        end else if (hasSecond(cur_r.op)) begin
          state_nxt = S_CMD2;
        end else begin
          state_nxt = S_FINISH;
        end
      end
      S_DATA: begin
        if (writesData(cur_r.op)) begin
          bcKind  = nand_host_pkg::CYC_WDATA;
          bcByte  = wrData;
          bcStart = wrValid;
          wrReady = bcDone;
        end else begin
          bcKind  = nand_host_pkg::CYC_RDATA;
          bcStart = 1'b1;
        end
        if (bcDone) begin
          bcStart     = 1'b0;
          rdValid_nxt = !writesData(cur_r.op);
          left_nxt    = left_r - 12'h001;
          if (left_r == 12'h001) begin
            state_nxt = hasSecond(cur_r.op) && writesData(cur_r.op) ? S_CMD2 : S_FINISH;
          end
        end
      end
      S_CMD2: begin
        bcStart = 1'b1;
        bcByte  = secondCmd(cur_r.op);
        if (bcDone) begin
          bcStart   = 1'b0;
          gap_nxt   = 3'(nand_host_pkg::WB_CYC);
          state_nxt = makesBusy(cur_r.op) ? S_BUSYWAIT : S_GAP;
          if (cur_r.op == nand_host_pkg::OP_RAND_OUT) begin
            left_nxt  = cur_r.count;
            cur_nxt.op = nand_host_pkg::OP_STATUS; // Reuse read-out path
          end
        end
      end
      S_BUSYWAIT: begin
        // Busy edge may come late; wait past the WE-high-to-busy limit
        if (gap_r != 3'd0) begin
          gap_nxt = gap_r - 3'd1;
        end else begin
          state_nxt = S_WAITRDY;
        end
      end
      S_WAITRDY: begin
        if (rbSync_r) begin
          state_nxt = (cur_r.op == nand_host_pkg::OP_READ && left_r != 12'h000) ?
                      S_DATA : S_FINISH;
        end
      end
      S_FINISH: begin
        opDone = 1'b1;
        if (cur_r.op == nand_host_pkg::OP_COPY_READ) begin
          copyDone_nxt = 1'b1;
        end else if (cur_r.op != nand_host_pkg::OP_EDC_STATUS &&
                     cur_r.op != nand_host_pkg::OP_STATUS &&
                     cur_r.op != nand_host_pkg::OP_COPY_PROG) begin
          copyDone_nxt = 1'b0;
        end
        state_nxt = S_IDLE;
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r    <= S_IDLE;
      cur_r      <= '0;
      addrIdx_r  <= 3'd0;
      addrEnd_r  <= 3'd0;
      left_r     <= 12'h000;
      gap_r      <= 3'd0;
      copyDone_r <= 1'b0;
      rdValid_r  <= 1'b0;
    end else if (clkEn) begin
      state_r    <= state_nxt;
      cur_r      <= cur_nxt;
      addrIdx_r  <= addrIdx_nxt;
      addrEnd_r  <= addrEnd_nxt;
      left_r     <= left_nxt;
      gap_r      <= gap_nxt;
      copyDone_r <= copyDone_nxt;
      rdValid_r  <= rdValid_nxt;
    end
  end

endmodule

// *** nand_host_monitor.sv ***
// Checker of the flash host pin protocol
`timescale 1ns/1ns
module nand_host_monitor (
  input wire logic                 clock,
  input wire logic                 rst,
  input wire logic                 reqValid,
  input wire logic                 reqReady,
  input wire nand_host_pkg::req_t  req,
  input wire logic                 rdValid_r,
  input wire logic                 opDone,
  input wire logic                 refused,
  input wire logic                 flashReady,
  input wire nand_host_pkg::pins_t pins,
  input wire logic [7:0]           ioOut,
  input wire logic                 ioOe,
  input wire logic                 readyBusyN
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Write strobe is a one-clock pulse
  property p_wrPulse; $fell(pins.writeStrobeN) |=> $rose(pins.writeStrobeN); endproperty
  a_wrPulse: assert property (p_wrPulse) else $error("write strobe too long");
  // Byte driven and steady while strobe is low
  property p_wrDrive; !pins.writeStrobeN |-> ioOe && $stable(ioOut); endproperty
  a_wrDrive: assert property (p_wrDrive) else $error("bus not driven under strobe");
  // Device stays selected, never write protected
  property p_select; !pins.chipSelN && pins.writeProtN; endproperty
  a_select: assert property (p_select) else $error("select or protect wrong");
  // Never both latches
  property p_latchOne; !(pins.cmdLatch && pins.addrLatch); endproperty
  a_latchOne: assert property (p_latchOne) else $error("both latches high");
  // Latch kind must not move across the strobe rise
  property p_latchHold; !pins.writeStrobeN |=> $stable({pins.cmdLatch, pins.addrLatch});
  endproperty
  a_latchHold: assert property (p_latchHold) else $error("latch moved at rise");
  // Read strobe only with the bus released and no write
  property p_rdFree; !pins.readStrobeN |-> !ioOe && pins.writeStrobeN; endproperty
  a_rdFree: assert property (p_rdFree) else $error("read strobe with bus driven");
  // Every read strobe hands one byte to the user
  property p_rdByte; $rose(pins.readStrobeN) |-> ##[1:3] rdValid_r; endproperty
  a_rdByte: assert property (p_rdByte) else $error("read byte not delivered");
  // Busy seen through two sync flops
  property p_busySync; $fell(readyBusyN) |-> ##2 !flashReady; endproperty
  a_busySync: assert property (p_busySync) else $error("busy not seen");
  // Array operations are refused while busy
  property p_busyRefuse;
    reqValid && reqReady && !flashReady &&
    (req.op inside {nand_host_pkg::OP_READ, nand_host_pkg::OP_PROGRAM, nand_host_pkg::OP_ERASE})
    |-> refused;
  endproperty
  a_busyRefuse: assert property (p_busyRefuse) else $error("op taken while busy");
  // A refused request leaves the pins quiet
  property p_refQuiet; refused |=> pins.writeStrobeN [*2]; endproperty
  a_refQuiet: assert property (p_refQuiet) else $error("pins moved on refusal");
  // Completion returns to idle
  property p_doneIdle; opDone |=> reqReady; endproperty
  a_doneIdle: assert property (p_doneIdle) else $error("not idle after done");
endmodule

// *** nand_flash_model.sv ***
// Behavioural flash device seen by the host
`timescale 1ns/1ns
module nand_flash_model #(
  parameter int         BUSY_NS = 2000,
  parameter logic [7:0] ID_BASE = 8'hA5 // Arbitrary identifier value
) (
  input  wire nand_host_pkg::pins_t pins,
  input  wire logic [7:0]           ioOut,
  input  wire logic                 ioOe,
  input  wire logic                 holdBusy,
  output logic [7:0]                ioIn,
  output logic                      readyBusyN
);
  logic [9:0]  logQ[$];
  logic [7:0]  cmd = 8'h00;
  logic [7:0]  dout = 8'h00;
  logic [11:0] col = 12'h000;
  logic [15:0] row = 16'h0000;
  logic        busy = 1'b0;
  logic        drv = 1'b0;
  int          idx;
  int          na = 0;
  event        goBusy;
  // Open drain pulled up; a released bus shows the inverse of the last byte
  assign readyBusyN = !(busy || holdBusy);
  assign ioIn = drv ? dout : (ioOe ? ioOut : ~dout);
  // Bytes taken at the write strobe rise
  always @(posedge pins.writeStrobeN) begin
    if (pins.chipSelN === 1'b0) begin
      if (pins.cmdLatch === 1'b1) begin
        cmd = ioOut;
        na = 0;
        logQ.push_back({2'd1, ioOut});
        if (ioOut inside {8'h30, 8'h35, 8'h10, 8'hD0, 8'hFF}) -> goBusy;
      end else if (pins.addrLatch === 1'b1) begin
        logQ.push_back({2'd2, ioOut});
        idx = (cmd == 8'h60) ? na + 2 : na;
        if (idx == 0) col = {4'h0, ioOut};
        if (idx == 1) col[11:8] = ioOut[3:0];
        if (idx == 2) row[7:0] = ioOut;
        if (idx == 3) row[15:8] = ioOut;
        na++;
      end else begin
        logQ.push_back({2'd3, ioOut});
        col++;
      end
    end
  end
  // Array operation time; status reads stay possible meanwhile
  always @(goBusy) begin
    busy = 1'b1;
    #BUSY_NS;
    busy = 1'b0;
  end
  // Each read strobe fall drives a byte and steps the column
  always @(negedge pins.readStrobeN) begin
    if (pins.chipSelN === 1'b0) begin
      if (cmd inside {8'h70, 8'h7B}) dout = {1'b1, readyBusyN, 6'h00};
      else if (cmd == 8'h90) dout = ID_BASE + col[7:0];
      else dout = col[7:0] ^ row[7:0];
      col++;
      drv = 1'b1;
    end
  end
  // Output hold runs out after the strobe rise
  always @(posedge pins.readStrobeN) begin
    #150;
    drv = 1'b0;
  end
endmodule

// *** nand_flash_command_interface_tb.sv ***
// Testbench of the flash host sequencer
`timescale 1ns/1ns
module nand_flash_command_interface_tb;
  logic                 clock = 1'b0;
  logic                 rst = 1'b1;
  logic                 reqValid = 1'b0;
  logic                 wrValid = 1'b0;
  logic                 holdBusy = 1'b0;
  logic [7:0]           wrData = 8'h00;
  nand_host_pkg::req_t  req = '0;
  logic                 reqReady, wrReady, rdValid_r, opDone, refused, flashReady, ioOe;
  logic                 readyBusyN;
  logic [7:0]           rdData_r, ioOut, ioIn;
  nand_host_pkg::pins_t pins;
  logic [9:0]           ex[$];
  logic [7:0]           wq[$], rq[$], rx[$];
  int                   n_fail = 0;
  int                   check_count = 0;

  nand_host_ctrl nand_host_ctrl_i (.clock(clock), .rst(rst), .clkEn(1'b1),
    .reqValid(reqValid), .reqReady(reqReady), .req(req), .wrValid(wrValid),
    .wrReady(wrReady), .wrData(wrData), .rdValid_r(rdValid_r), .rdData_r(rdData_r),
    .opDone(opDone), .refused(refused), .flashReady(flashReady), .pins(pins),
    .ioOut(ioOut), .ioOe(ioOe), .ioIn(ioIn), .readyBusyN(readyBusyN));
  nand_flash_model nand_flash_model_i (.pins(pins), .ioOut(ioOut), .ioOe(ioOe),
    .holdBusy(holdBusy), .ioIn(ioIn), .readyBusyN(readyBusyN));

  // Clock of 100 ns
  initial begin
    forever #50 clock = ~clock;
  end

  task check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task test_done;
    if (n_fail == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // One request; pin log and read bytes compared with ex and rx
  task run_op(input nand_host_pkg::op_t op, input logic [27:0] ad, input logic [11:0] n,
              input logic rf);
    int wi;
    int k;
    logic tk;
    wi = 0;
    tk = 1'b0;
    rq = {};
    @(negedge clock);
    req = '{op, ad, n};
    reqValid = 1'b1;
    wrValid = (wq.size() > 0);
    if (wq.size() > 0) wrData = wq[0];
    #10 check(refused, rf);
    @(negedge clock);
    reqValid = 1'b0;
    // Data bytes advance only after the edge that consumed them
    for (k = 0; k < 3000 && !rf; k++) begin
      if (tk) begin
        wi++;
        wrValid = (wi < wq.size());
        if (wi < wq.size()) wrData = wq[wi];
      end
      tk = (wrReady === 1'b1);
      if (rdValid_r === 1'b1) rq.push_back(rdData_r);
      if (opDone === 1'b1) break;
      @(negedge clock);
    end
    if (k >= 3000) check(0, 1);
    check(nand_flash_model_i.logQ.size(), ex.size());
    foreach (ex[i]) check(nand_flash_model_i.logQ[i], ex[i]);
    check(rq.size(), rx.size());
    foreach (rx[i]) check(rq[i], rx[i]);
    nand_flash_model_i.logQ = {};
    wq = {};
  endtask

  task t_edcEarly;
    ex = {};
    rx = {};
    run_op(nand_host_pkg::OP_EDC_STATUS, 28'h0, 12'h1, 1'b1);
  endtask

  task t_statusId;
    ex = '{10'h170};
    rx = '{8'hC0};
    run_op(nand_host_pkg::OP_STATUS, 28'h0, 12'h1, 1'b0);
    ex = '{10'h190, 10'h200};
    rx = '{8'hA5, 8'hA6};
    run_op(nand_host_pkg::OP_READ_ID, 28'h0, 12'h2, 1'b0);
  endtask

  task t_readSpare;
    ex = '{10'h100, 10'h203, 10'h208, 10'h234, 10'h212, 10'h130};
    rx = '{8'h37, 8'h30};
    run_op(nand_host_pkg::OP_READ, 28'h1234803, 12'h2, 1'b0);
  endtask

  task t_progErase;
    wq = '{8'hAA, 8'h55};
    ex = '{10'h180, 10'h205, 10'h200, 10'h241, 10'h200, 10'h3AA, 10'h355, 10'h110};
    rx = {};
    run_op(nand_host_pkg::OP_PROGRAM, 28'h0041005, 12'h2, 1'b0);
    wq = '{8'h3C};
    ex = '{10'h185, 10'h207, 10'h200, 10'h33C};
    run_op(nand_host_pkg::OP_RAND_IN, 28'h0000007, 12'h1, 1'b0);
    ex = '{10'h160, 10'h280, 10'h200, 10'h1D0};
    run_op(nand_host_pkg::OP_ERASE, 28'h0080000, 12'h0, 1'b0);
  endtask

  task t_copyBack;
    ex = '{10'h100, 10'h200, 10'h200, 10'h201, 10'h200, 10'h135};
    rx = {};
    run_op(nand_host_pkg::OP_COPY_READ, 28'h0001000, 12'h0, 1'b0);
    ex = '{10'h17B};
    rx = '{8'hC0};
    run_op(nand_host_pkg::OP_EDC_STATUS, 28'h0, 12'h1, 1'b0);
    ex = '{10'h185, 10'h200, 10'h200, 10'h202, 10'h200, 10'h110};
    rx = {};
    run_op(nand_host_pkg::OP_COPY_PROG, 28'h0002000, 12'h0, 1'b0);
    ex = '{10'h105, 10'h210, 10'h200, 10'h1E0};
    rx = '{8'h12};
    run_op(nand_host_pkg::OP_RAND_OUT, 28'h0002010, 12'h1, 1'b0);
  endtask

  // Device held busy: array ops refused, status still served
  task t_busy;
    holdBusy = 1'b1;
    repeat (4) @(negedge clock);
    ex = {};
    rx = {};
    run_op(nand_host_pkg::OP_PROGRAM, 28'h0, 12'h0, 1'b1);
    run_op(nand_host_pkg::OP_READ, 28'h0, 12'h0, 1'b1);
    ex = '{10'h170};
    rx = '{8'h80};
    run_op(nand_host_pkg::OP_STATUS, 28'h0, 12'h1, 1'b0);
    holdBusy = 1'b0;
    repeat (4) @(negedge clock);
  endtask

  task t_reset;
    ex = '{10'h1FF};
    rx = {};
    run_op(nand_host_pkg::OP_RESET, 28'h0, 12'h0, 1'b0);
  endtask

  // Main sequence
  initial begin
    repeat (2) @(negedge clock);
    rst = 1'b0;
    nand_flash_model_i.logQ = {}; // Strobe rise out of reset is no byte
    t_edcEarly();
    t_statusId();
    t_readSpare();
    t_progErase();
    t_copyBack();
    t_busy();
    t_reset();
    test_done();
  end

  // Watchdog well beyond the expected run
  initial begin
    #2000000;
    n_fail++;
    test_done();
  end
endmodule

bind nand_host_ctrl nand_host_monitor nand_host_monitor_i (.clock(clock), .rst(rst),
  .reqValid(reqValid), .reqReady(reqReady), .req(req), .rdValid_r(rdValid_r),
  .opDone(opDone), .refused(refused), .flashReady(flashReady), .pins(pins),
  .ioOut(ioOut), .ioOe(ioOe), .readyBusyN(readyBusyN));
